// [common/lcdcm_defines.vh]
// constants for the lcd common map and power control block
`ifndef LCDCM_DEFINES_VH
`define LCDCM_DEFINES_VH
// instruction opcodes; power and divider are upper five bits, the rest full bytes, scan and bias with masks
`define LCDCM_OP_POWER      5'h05
`define LCDCM_OP_DIVIDER    5'h04
`define LCDCM_OP_CONTRAST   8'h81
`define LCDCM_OP_SCAN_MASK  8'hF0
`define LCDCM_OP_SCAN       8'hC0
`define LCDCM_OP_BIAS_MASK  8'hFE
`define LCDCM_OP_BIAS       8'hA2
`define LCDCM_OP_RESET      8'hE2
// reset values
`define LCDCM_RST_POWER     3'h0
`define LCDCM_RST_DIVIDER   3'h4
`define LCDCM_RST_CONTRAST  6'h20
// duty codes
`define LCDCM_DUTY_33       2'h0
`define LCDCM_DUTY_49       2'h1
`define LCDCM_DUTY_55       2'h2
`define LCDCM_DUTY_65       2'h3
// logical lines in lower half per duty
`define LCDCM_HALF_33       7'h10
`define LCDCM_HALF_49       7'h18
`define LCDCM_HALF_55       7'h1B
`define LCDCM_HALF_65       7'h20
// channel counts
`define LCDCM_NUM_COM       64
`define LCDCM_NUM_SEG       132
`endif

// [rtl/lcdcm_common_power.v]
// common map, power enable, contrast and divider control of the lcd driver
`timescale 1ns/1ps
`include "lcdcm_defines.vh"
module lcdcm_common_power (
   input  wire         i_clk,
   input  wire         i_rst_b,
   input  wire         i_cmd_valid,
   input  wire [7:0]   i_cmd_data,
   input  wire         i_master,
   input  wire         i_duty_sel_hi,
   input  wire         i_duty_sel_lo,
   input  wire         i_internal_divider_strap,
   input  wire         i_high_power_strap_n,
   input  wire         i_frame_start,
   input  wire         i_frame_polarity,
   input  wire [5:0]   i_line_index,
   input  wire         i_line_active,
   input  wire [131:0] i_seg_data,
   input  wire [1:0]   i_icon_data,
   output reg  [63:0]  o_com_select,
   output reg  [63:0]  o_com_level,
   output reg  [1:0]   o_icon_common,
   output reg  [131:0] o_seg_level,
   output reg          o_converter_enable,
   output reg          o_regulator_enable,
   output reg          o_follower_enable,
   output reg  [5:0]   o_contrast_level,
   output reg  [2:0]   o_divider_ratio_select,
   output reg  [6:0]   o_divider_gain_x10,
   output reg          o_internal_divider,
   output reg          o_high_power,
   output reg  [1:0]   o_duty,
   output reg  [3:0]   o_bias_den
);

//------------------------------------------------------------
// strap synchronisers
//------------------------------------------------------------
reg [2:0] duty_hi_s, duty_lo_s, intr_s, hpm_s, mst_s;
reg       duty_hi, duty_lo, intr, hpm_n, mst;

// three stages, change accepted when stages two and three agree
always @(posedge i_clk or negedge i_rst_b) begin
   if (!i_rst_b) begin
      duty_hi_s <= 3'h0;
      duty_lo_s <= 3'h0;
      intr_s    <= 3'h0;
      hpm_s     <= 3'h7;
      mst_s     <= 3'h0;
      duty_hi   <= 1'b0;
      duty_lo   <= 1'b0;
      intr      <= 1'b0;
      hpm_n     <= 1'b1;
      mst       <= 1'b0;
   end else begin
      duty_hi_s <= {duty_hi_s[1:0], i_duty_sel_hi};
      duty_lo_s <= {duty_lo_s[1:0], i_duty_sel_lo};
      intr_s    <= {intr_s[1:0], i_internal_divider_strap};
      hpm_s     <= {hpm_s[1:0], i_high_power_strap_n};
      mst_s     <= {mst_s[1:0], i_master};
      if (duty_hi_s[1] == duty_hi_s[2]) duty_hi <= duty_hi_s[2];
      if (duty_lo_s[1] == duty_lo_s[2]) duty_lo <= duty_lo_s[2];
      if (intr_s[1] == intr_s[2]) intr <= intr_s[2];
      if (hpm_s[1] == hpm_s[2]) hpm_n <= hpm_s[2];
      if (mst_s[1] == mst_s[2]) mst <= mst_s[2];
   end
end

//------------------------------------------------------------
// instruction registers
//------------------------------------------------------------
reg [2:0] power_bits;
reg [5:0] contrast_level;
reg [2:0] divider_ratio_select;
reg       common_scan_reverse;
reg       bias_alt;
reg       contrast_pending;

// decode of instruction bytes, second byte after contrast opcode is data
always @(posedge i_clk or negedge i_rst_b) begin
   if (!i_rst_b) begin
      power_bits           <= `LCDCM_RST_POWER;
      contrast_level       <= `LCDCM_RST_CONTRAST;
      divider_ratio_select <= `LCDCM_RST_DIVIDER;
      common_scan_reverse  <= 1'b0;
      bias_alt             <= 1'b0;
      contrast_pending     <= 1'b0;
   end else if (i_cmd_valid) begin
      contrast_pending <= 1'b0;
      if (contrast_pending) begin
         contrast_level <= i_cmd_data[5:0];
      end else if (i_cmd_data == `LCDCM_OP_CONTRAST) begin
         contrast_pending <= 1'b1;
      end else if (i_cmd_data == `LCDCM_OP_RESET) begin
         contrast_level       <= `LCDCM_RST_CONTRAST;
         divider_ratio_select <= `LCDCM_RST_DIVIDER;
         common_scan_reverse  <= 1'b0;
      end else if (i_cmd_data[7:3] == `LCDCM_OP_POWER) begin
         power_bits <= i_cmd_data[2:0];
      end else if (i_cmd_data[7:3] == `LCDCM_OP_DIVIDER) begin
         divider_ratio_select <= i_cmd_data[2:0];
      end else if ((i_cmd_data & `LCDCM_OP_SCAN_MASK) == `LCDCM_OP_SCAN) begin
         common_scan_reverse <= i_cmd_data[3];
      end else if ((i_cmd_data & `LCDCM_OP_BIAS_MASK) == `LCDCM_OP_BIAS) begin
         bias_alt <= i_cmd_data[0];
      end
   end
end

//------------------------------------------------------------
// frame-aligned scan settings
//------------------------------------------------------------
reg       scan_rev_f;
reg [1:0] duty_f;

// latch direction and duty only at a frame start
always @(posedge i_clk or negedge i_rst_b) begin
   if (!i_rst_b) begin
      scan_rev_f <= 1'b0;
      duty_f     <= `LCDCM_DUTY_33;
   end else if (i_frame_start) begin
      scan_rev_f <= common_scan_reverse;
      duty_f     <= {duty_hi, duty_lo};
   end
end

//------------------------------------------------------------
// common pin mapping
//------------------------------------------------------------
function [6:0] half_of;
   input [1:0] d;
   begin
      case (d)
         `LCDCM_DUTY_33: half_of = `LCDCM_HALF_33;
         `LCDCM_DUTY_49: half_of = `LCDCM_HALF_49;
         `LCDCM_DUTY_55: half_of = `LCDCM_HALF_55;
         default:        half_of = `LCDCM_HALF_65;
      endcase
   end
endfunction

wire [6:0] half    = half_of(duty_f);
wire [6:0] nlines  = {half[5:0], 1'b0};
wire [6:0] line_in = {1'b0, i_line_index};
// reversed order counts logical lines from the far end
wire [6:0] logical = scan_rev_f ? (nlines - 7'h01 - line_in) : line_in;
// lower half on lowest pins, upper half ends at pin 63
wire [6:0] pin     = (logical < half) ? logical :
                     (logical + 7'h40 - nlines);
wire       in_range = i_line_active && (line_in < nlines);

genvar g;
// each physical common selected when its pin matches the scanned line
generate
   for (g = 0; g < `LCDCM_NUM_COM; g = g + 1) begin : g_com
      always @(posedge i_clk or negedge i_rst_b) begin
         if (!i_rst_b) begin
            o_com_select[g] <= 1'b0;
            o_com_level[g]  <= 1'b0;
         end else begin
            o_com_select[g] <= in_range && (pin == g);
            o_com_level[g]  <= (in_range && (pin == g)) ^ i_frame_polarity;
         end
      end
   end
endgenerate

//------------------------------------------------------------
// segment and icon drive, power and analog control outputs
//------------------------------------------------------------
// drive level from pixel and polarity; decoded power and divider controls
always @(posedge i_clk or negedge i_rst_b) begin
   if (!i_rst_b) begin
      o_seg_level            <= {`LCDCM_NUM_SEG{1'b0}};
      o_icon_common          <= 2'h0;
      o_converter_enable     <= 1'b0;
      o_regulator_enable     <= 1'b0;
      o_follower_enable      <= 1'b0;
      o_contrast_level       <= `LCDCM_RST_CONTRAST;
      o_divider_ratio_select <= `LCDCM_RST_DIVIDER;
      o_divider_gain_x10     <= 7'h32;
      o_internal_divider     <= 1'b0;
      o_high_power           <= 1'b0;
      o_duty                 <= `LCDCM_DUTY_33;
      o_bias_den             <= 4'h6;
   end else begin
      o_seg_level        <= i_seg_data ^ {`LCDCM_NUM_SEG{i_frame_polarity}};
      o_icon_common      <= i_icon_data ^ {2{i_frame_polarity}};
      o_converter_enable <= mst & power_bits[2];
      o_regulator_enable <= mst & power_bits[1];
      o_follower_enable  <= mst & power_bits[0];
      o_contrast_level       <= contrast_level;
      o_divider_ratio_select <= divider_ratio_select;
      // gain times ten is 30 plus five per code step, 64 at the top code
      o_divider_gain_x10 <= (divider_ratio_select == 3'h7) ? 7'h40 :
                            (7'h1E + {2'b00, divider_ratio_select, 2'b00} +
                             {4'h0, divider_ratio_select});
      o_internal_divider <= intr;
      o_high_power       <= ~hpm_n;
      o_duty             <= duty_f;
      case (duty_f)
         `LCDCM_DUTY_33: o_bias_den <= bias_alt ? 4'h5 : 4'h6;
         `LCDCM_DUTY_49: o_bias_den <= bias_alt ? 4'h6 : 4'h8;
         `LCDCM_DUTY_55: o_bias_den <= bias_alt ? 4'h6 : 4'h8;
         default:        o_bias_den <= bias_alt ? 4'h7 : 4'h9;
      endcase
   end
end

endmodule

// [verification/lcdcm_panel.sv]
// panel model: reports which physical common row is driven
`timescale 1ns/1ps
module lcdcm_panel (
   input  wire logic [63:0] i_com_select,
   output logic      [6:0]  o_row
);
   // row 64 means no common pin is driven
   always_comb begin
      o_row = 7'h40;
      for (int k = 0; k < 64; k++) if (i_com_select[k]) o_row = k[6:0];
   end
endmodule

// [verification/lcdcm_props_properties.sv]
// port assertions for the common map and power control block
`timescale 1ns/1ps
module lcdcm_props (
   input logic        i_clk,
   input logic        i_rst_b,
   input logic        i_cmd_valid,
   input logic [7:0]  i_cmd_data,
   input logic        i_master,
   input logic        i_high_power_strap_n,
   input logic        i_frame_start,
   input logic        i_frame_polarity,
   input logic [1:0]  i_icon_data,
   input logic [63:0] o_com_select,
   input logic [1:0]  o_icon_common,
   input logic        o_converter_enable,
   input logic        o_regulator_enable,
   input logic        o_follower_enable,
   input logic [5:0]  o_contrast_level,
   input logic [2:0]  o_divider_ratio_select,
   input logic [6:0]  o_divider_gain_x10,
   input logic        o_high_power,
   input logic [1:0]  o_duty
);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_b);
   wire [2:0] pwr = {o_converter_enable, o_regulator_enable, o_follower_enable};
   // power write not consumed as contrast data, and a contrast pair
   sequence s_pwr;
      i_master[*5] ##0 (i_cmd_valid && i_cmd_data[7:3] == 5'h05 &&
      !$past(i_cmd_valid && i_cmd_data == 8'h81));
   endsequence
   sequence s_ctr; i_cmd_valid && i_cmd_data == 8'h81 ##1 i_cmd_valid; endsequence
   property p_pwr; s_pwr |-> ##2 pwr == $past(i_cmd_data[2:0], 2); endproperty
   a_pwr: assert property (p_pwr) else $error("power bits");
   property p_ctr; s_ctr |-> ##3 o_contrast_level == $past(i_cmd_data[5:0], 3); endproperty
   a_ctr: assert property (p_ctr) else $error("contrast code");
   property p_slave; !i_master[*6] |-> pwr == 3'h0; endproperty
   a_slave: assert property (p_slave) else $error("enable in slave");
   property p_onehot; 1 |-> $onehot0(o_com_select); endproperty
   a_onehot: assert property (p_onehot) else $error("common select");
   property p_hp; $stable(i_high_power_strap_n)[*5] |-> o_high_power == !i_high_power_strap_n; endproperty
   a_hp: assert property (p_hp) else $error("high power");
   property p_duty; !i_frame_start[*3] |=> $stable(o_duty); endproperty
   a_duty: assert property (p_duty) else $error("duty off frame");
   property p_gain; $stable(o_divider_ratio_select)[*2] |-> o_divider_gain_x10 ==
      (o_divider_ratio_select == 3'h7 ? 7'h40 : 7'h1E + 7'h05 * o_divider_ratio_select);
   endproperty
   a_gain: assert property (p_gain) else $error("divider gain");
   property p_icon; $stable({i_icon_data, i_frame_polarity})[*3] |->
      o_icon_common == (i_icon_data ^ {2{i_frame_polarity}}); endproperty
   a_icon: assert property (p_icon) else $error("icon level");
endmodule
bind lcdcm_common_power lcdcm_props u_props (.*);

// [verification/test_lcd_common_map_and_power_ctl.sv]
// self-checking bench for the common map and power control block
`timescale 1ns/1ps
`define CHK(n, e, a) begin comparisons++; if ((a) !== (e)) begin fails++; \
   $display("CHECK FAILED %s exp %0h got %0h", n, e, a); end end
module test_lcd_common_map_and_power_ctl;
   logic i_clk = 0, i_rst_b = 0, i_cmd_valid = 0, i_master = 1, i_duty_sel_hi = 0;
   logic i_duty_sel_lo = 0, i_internal_divider_strap = 0, i_high_power_strap_n = 1;
   logic i_frame_start = 0, i_frame_polarity = 0, i_line_active = 0;
   logic [7:0] i_cmd_data = 0;
   logic [5:0] i_line_index = 0, o_contrast_level;
   logic [131:0] i_seg_data = 0, o_seg_level;
   logic [1:0] i_icon_data = 0, o_icon_common, o_duty, pd = 0;
   logic [63:0] o_com_select, o_com_level;
   logic o_converter_enable, o_regulator_enable, o_follower_enable, o_internal_divider;
   logic o_high_power;
   logic [2:0] o_divider_ratio_select, pw[4] = '{3'h7, 3'h3, 3'h1, 3'h0};
   logic [6:0] o_divider_gain_x10, row;
   logic [3:0] o_bias_den;
   wire [2:0] pwr = {o_converter_enable, o_regulator_enable, o_follower_enable};
   int fails = 0, comparisons = 0, l, x, e, h[4] = '{16, 24, 27, 32}, bd[4] = '{6, 8, 8, 9};
   lcdcm_common_power DUT (.*);
   lcdcm_panel PANEL (.i_com_select(o_com_select), .o_row(row));
   // 20 MHz clock
   always #25 i_clk = ~i_clk;
   // one instruction byte per clock, valid stays up across back to back bytes
   task automatic w(input logic [7:0] b);
      i_cmd_valid = 1;
      i_cmd_data = b;
      @(negedge i_clk);
   endtask
   task automatic idle(input int n);
      i_cmd_valid = 0;
      repeat (n) @(negedge i_clk);
   endtask
   task automatic close_out;
      $display("comparisons %0d mismatches %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   // hang guard
   initial begin
      repeat (5000) @(posedge i_clk);
      fails++;
      close_out;
   end
   // main sequence
   initial begin
      repeat (20) @(negedge i_clk);
      i_rst_b = 1;
      idle(1);
      `CHK("contrast", 6'h20, o_contrast_level)
      `CHK("ratio", 3'h4, o_divider_ratio_select)
      `CHK("power", 3'h0, pwr)
      `CHK("bias", 4'h6, o_bias_den)
      foreach (pw[k]) begin
         w({5'h05, pw[k]});
         idle(4);
         `CHK("power", pw[k], pwr)
      end
      i_master = 0;
      idle(6);
      w(8'h2F);
      idle(4);
      `CHK("slave", 3'h0, pwr)
      i_master = 1;
      idle(6);
      `CHK("master", 3'h7, pwr)
      for (int r = 0; r < 8; r++) begin
         w({5'h04, r[2:0]});
         idle(4);
         `CHK("ratio", r[2:0], o_divider_ratio_select)
         `CHK("gain", (r == 7) ? 64 : 30 + 5 * r, o_divider_gain_x10)
      end
      w(8'h81);
      w(8'h3F);
      w(8'h81);
      w(8'h2F);
      idle(4);
      `CHK("contrast", 6'h2F, o_contrast_level)
      `CHK("power kept", 3'h7, pwr)
      w(8'hE2);
      idle(4);
      `CHK("contrast", 6'h20, o_contrast_level)
      `CHK("ratio", 3'h4, o_divider_ratio_select)
      i_high_power_strap_n = 0;
      i_internal_divider_strap = 1;
      i_frame_polarity = 1;
      i_icon_data = 2'h1;
      i_seg_data = {33{4'h5}};
      idle(6);
      `CHK("high power", 1'h1, o_high_power)
      `CHK("divider", 1'h1, o_internal_divider)
      `CHK("icon", 2'h2, o_icon_common)
      `CHK("seg", {33{4'hA}}, o_seg_level)
      for (int d = 0; d < 4; d++) for (int s = 0; s < 2; s++) begin
         {i_duty_sel_hi, i_duty_sel_lo} = d[1:0];
         w({4'hC, s[0], 3'h0});
         idle(6);
         `CHK("duty held", pd, o_duty)
         i_frame_start = 1;
         idle(1);
         i_frame_start = 0;
         idle(3);
         pd = d[1:0];
         `CHK("duty", pd, o_duty)
         `CHK("bias", bd[d], o_bias_den)
         for (int k = 0; k < 5; k++) begin
            l = (k + 1) / 2 * h[d] - k % 2;
            x = s ? 2 * h[d] - 1 - l : l;
            e = (l >= 2 * h[d]) ? 64 : (x < h[d]) ? x : x + 64 - 2 * h[d];
            i_line_index = l[5:0];
            i_line_active = 1;
            idle(2);
            if (l < 64) begin
               `CHK("row", e[6:0], row)
               `CHK("com level", ~((e < 64) ? (64'h1 << e) : 64'h0), o_com_level)
            end
         end
      end
      w(8'hA3);
      idle(4);
      `CHK("bias alt", 4'h7, o_bias_den)
      close_out;
   end
endmodule
